// File: tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CPB   = 8;
  localparam int FRAME = (1 + udt_pkg::DATA_BITS + udt_pkg::STOP_BITS) * CPB;
  logic               clk, sys_rst, flow_ctrl_en, tx_valid, cts_go, en_q, txd_q, cts_q;
  logic [7:0]         tx_data, rx_data;
  logic               tx_ready, cts_n, tx_busy, rx_stop, rx_done;
  udt_pkg::udt_line_t line;
  int                 mismatches, checks_done, seed, cyc, t_rise, t_fall, t_start, t_cts;
  logic [7:0]         exp_q[$];

  udt_uart_tx #(.CLKS_PER_BIT(CPB)) u_udt_uart_tx (.clk(clk), .sys_rst(sys_rst),
    .flow_ctrl_en(flow_ctrl_en), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .cts_n(cts_n), .line(line), .tx_busy(tx_busy));
  udt_line_partner #(.CLKS_PER_BIT(CPB)) u_udt_line_partner (.clk(clk), .line(line),
    .cts_go(cts_go), .cts_n(cts_n), .rx_data(rx_data), .rx_stop(rx_stop), .rx_done(rx_done));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // edge times seen as pre-edge values, so all share one offset
  always @(posedge clk) begin
    cyc++;
    if (line.line_driver_enable && !en_q) t_rise = cyc;
    if (!line.line_driver_enable && en_q) t_fall = cyc;
    if (!line.txd && txd_q && t_start < t_rise) t_start = cyc;
    if (!cts_n && cts_q) t_cts = cyc;
    en_q = line.line_driver_enable;
    txd_q = line.txd;
    cts_q = cts_n;
    if (rx_done) begin
      if (exp_q.size() == 0) check("rx_extra", 1, 0);
      else check("rx_data", rx_data, exp_q.pop_front());
      check("rx_stop", rx_stop, 1);
    end
  end
  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  // tx_valid stays up between writes so no signal is driven twice per step
  task automatic wr(input logic [7:0] b);
    tx_valid <= 1'b1;
    tx_data <= b;
    for (int i = 0; i < 2000; i++) begin
      @(posedge clk);
      if (tx_ready === 1'b1) begin
        exp_q.push_back(b);
        return;
      end
    end
    check("wr_timeout", 0, 1);
    final_report();
  endtask
  task automatic wait_done();
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk);
      if (exp_q.size() == 0 && line.line_driver_enable === 1'b0 && t_fall > t_rise) return;
    end
    check("done_timeout", 0, 1);
    final_report();
  endtask

  initial begin
    seed = 32'h1c03;
    {sys_rst, flow_ctrl_en, tx_valid, cts_go, en_q, txd_q, cts_q} = 7'h40;
    tx_data = 8'h00;
    {cyc, t_rise, t_fall, t_start, t_cts} = '0;
    repeat (16) @(posedge clk);
    check("line_rst", line, udt_pkg::LINE_RESET);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    // single, then back-to-back characters without flow control
    for (int k = 1; k <= 4; k++) begin
      for (int j = 0; j < k; j++) wr(8'($random(seed)));
      tx_valid <= 1'b0;
      wait_done();
      check("lead", t_start - t_rise, udt_pkg::LEAD_CYCLES);
      check("en_len", t_fall - t_rise, udt_pkg::LEAD_CYCLES + k * FRAME);
      check("busy_end", tx_busy, 0);
      repeat (5) @(posedge clk);
    end
    // flow control: data waits for clear-to-send
    flow_ctrl_en <= 1'b1;
    wr(8'($random(seed)));
    tx_valid <= 1'b0;
    repeat (30) @(posedge clk);
    check("en_no_cts", line.line_driver_enable, 0);
    cts_go <= 1'b1;
    wait_done();
    check("cts_lat", t_rise - t_cts >= 2 && t_rise - t_cts <= 2 + CPB, 1);
    // fill the buffer while held off, a refused write, then drain
    cts_go <= 1'b0;
    repeat (4) @(posedge clk);
    for (int j = 0; j < 16; j++) wr(8'($random(seed)));
    tx_valid <= 1'b0;
    repeat (2) @(posedge clk);
    check("full", tx_ready, 0);
    tx_valid <= 1'b1;
    tx_data <= 8'ha5;
    repeat (3) @(posedge clk);
    tx_valid <= 1'b0;
    cts_go <= 1'b1;
    wait_done();
    check("en_len16", t_fall - t_rise, 16 * FRAME);
    final_report();
  end
endmodule

// File: udt_fifo.sv
module udt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = udt_pkg::FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
      $error("udt_fifo: depth must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             do_wr;
  logic             do_rd;

  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (do_wr && !do_rd) begin
      next_count = count + 1'b1;
    end else if (do_rd && !do_wr) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // ready is registered so the top sees it straight from a flop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      in_ready <= 1'b0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count    <= next_count;
      in_ready <= (next_count != FULL_COUNT);
    end
  end

endmodule

// File: udt_line_partner.sv
module udt_line_partner #(
  parameter int CLKS_PER_BIT = 8
) (
  input  wire logic               clk,
  input  wire udt_pkg::udt_line_t line,
  input  wire logic               cts_go,
  output logic                    cts_n,
  output logic [7:0]              rx_data,
  output logic                    rx_stop,
  output logic                    rx_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] b;
  // ----------------------------------------------------------------
  // remote station
  // ----------------------------------------------------------------
  // clear-to-send only once the bench has loaded data first
  assign cts_n = !cts_go;
  initial begin
    rx_done = 1'b0;
    rx_data = 8'h00;
    rx_stop = 1'b0;
  end
  // ----------------------------------------------------------------
  // transceiver receive side
  // ----------------------------------------------------------------
  // start seen one clock late, so half a bit lands mid-cell
  always begin
    do @(posedge clk); while (!(line.line_driver_enable && !line.txd));
    repeat (CLKS_PER_BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (CLKS_PER_BIT) @(posedge clk);
      b[i] = line.txd;
    end
    repeat (CLKS_PER_BIT) @(posedge clk);
    rx_stop <= line.txd;
    rx_data <= b;
    rx_done <= 1'b1;
    @(posedge clk);
    rx_done <= 1'b0;
  end
endmodule

// File: udt_pkg.sv
// Summary of operation
// - without cts, enable driver once character written
// - keep driver enabled across back-to-back characters
// - drop enable at stop end, no hold
// - cts fall to enable: two clocks to +1bit
// - start bit edge 1 clock after enable without cts, same clock as enable with cts
package udt_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int BAUD_DEFAULT  = 115200;
  localparam int CLKS_PER_BIT  = CLK_HZ / BAUD_DEFAULT;
  localparam int LEAD_CYCLES   = 1;

  // ----------------------------------------------------------------
  // frame and buffer shape
  // ----------------------------------------------------------------
  localparam int DATA_BITS  = 8;
  localparam int STOP_BITS  = 1;
  localparam int FIFO_DEPTH = 16;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic TXD_IDLE    = 1'b1;
  localparam logic ENABLE_RESET = 1'b0;
  localparam logic CTS_NEGATED = 1'b1;

  typedef enum logic [2:0] {
    UDT_IDLE  = 3'b000,
    UDT_LEAD  = 3'b001,
    UDT_START = 3'b010,
    UDT_DATA  = 3'b011,
    UDT_STOP  = 3'b100
  } udt_state_t;

  typedef struct packed {
    logic txd;
    logic line_driver_enable;
  } udt_line_t;

  localparam udt_line_t LINE_RESET = '{txd: TXD_IDLE, line_driver_enable: ENABLE_RESET};

endpackage

// File: udt_uart_tx.sv
module udt_uart_tx #(
  parameter int CLKS_PER_BIT = udt_pkg::CLKS_PER_BIT,
  parameter int STOP_BITS    = udt_pkg::STOP_BITS,
  parameter int FIFO_DEPTH   = udt_pkg::FIFO_DEPTH
) (
  input  wire logic                           clk,
  input  wire logic                           sys_rst,
  input  wire logic                           flow_ctrl_en,
  input  wire logic                           tx_valid,
  output logic                                tx_ready,
  input  wire logic [udt_pkg::DATA_BITS-1:0]  tx_data,
  input  wire logic                           cts_n,
  output udt_pkg::udt_line_t                  line,
  output logic                                tx_busy
);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  localparam int CW = $clog2(CLKS_PER_BIT);
  localparam int IW = $clog2(udt_pkg::DATA_BITS);
  localparam logic [CW-1:0] BIT_LAST  = CW'(CLKS_PER_BIT - 1);
  localparam logic [IW-1:0] DATA_LAST = IW'(udt_pkg::DATA_BITS - 1);
  localparam logic          STOP_LAST = 1'(STOP_BITS - 1);
  // two clocks plus one bit, one more for the edge that samples the fall
  localparam int            CTS_LAT_MAX = CLKS_PER_BIT + 3;

  generate
    if (CLKS_PER_BIT < 4 || CLKS_PER_BIT > 990 || STOP_BITS < 1 || STOP_BITS > 2) begin : g_bad
      $error("udt_uart_tx: unsupported bit length or stop bit count");
    end
  endgenerate

  // ----------------------------------------------------------------
  // holding buffer
  // ----------------------------------------------------------------
  logic                          fifo_valid;
  logic                          load;
  logic [udt_pkg::DATA_BITS-1:0] fifo_data;

  udt_fifo #(
    .WIDTH (udt_pkg::DATA_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (fifo_valid),
    .out_ready (load),
    .out_data  (fifo_data)
  );

  // ----------------------------------------------------------------
  // cts synchroniser
  // ----------------------------------------------------------------
  logic cts_s1;
  logic cts_s2;
  logic cts_s3;
  logic cts_flt;

  // a change counts only once the last two stages agree
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cts_s1  <= udt_pkg::CTS_NEGATED;
      cts_s2  <= udt_pkg::CTS_NEGATED;
      cts_s3  <= udt_pkg::CTS_NEGATED;
      cts_flt <= udt_pkg::CTS_NEGATED;
    end else begin
      cts_s1 <= cts_n;
      cts_s2 <= cts_s1;
      cts_s3 <= cts_s2;
      if (cts_s2 == cts_s3) begin
        cts_flt <= cts_s3;
      end
    end
  end

  // ----------------------------------------------------------------
  // bit timer
  // ----------------------------------------------------------------
  udt_pkg::udt_state_t state;
  logic [CW-1:0]       bit_cnt;
  logic                bit_done;

  assign bit_done = (bit_cnt == BIT_LAST);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bit_cnt <= '0;
    end else if (state == udt_pkg::UDT_IDLE || state == udt_pkg::UDT_LEAD || bit_done) begin
      bit_cnt <= '0;
    end else begin
      bit_cnt <= bit_cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // framing and driver enable
  // ----------------------------------------------------------------
  logic                          can_load;
  logic                          stop_end;
  logic [udt_pkg::DATA_BITS-1:0] shreg;
  logic [IW-1:0]                 data_idx;
  logic                          stop_idx;

  // with flow control the far end must be ready before each character
  assign can_load = fifo_valid && (!flow_ctrl_en || !cts_flt);
  assign stop_end = (state == udt_pkg::UDT_STOP) && bit_done && (stop_idx == STOP_LAST);
  assign load     = can_load && (state == udt_pkg::UDT_IDLE || stop_end);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state    <= udt_pkg::UDT_IDLE;
      line     <= udt_pkg::LINE_RESET;
      shreg    <= '0;
      data_idx <= '0;
      stop_idx <= 1'b0;
      tx_busy  <= 1'b0;
    end else begin
      unique case (state)
        udt_pkg::UDT_IDLE: begin
          if (load) begin
            shreg                   <= fifo_data;
            tx_busy                 <= 1'b1;
            line.line_driver_enable <= 1'b1;
            if (flow_ctrl_en) begin
              state    <= udt_pkg::UDT_START;
              line.txd <= 1'b0;
            end else begin
              state <= udt_pkg::UDT_LEAD;
            end
          end
        end
        udt_pkg::UDT_LEAD: begin
          // one clock of lead so the driver is on before the start edge
          state    <= udt_pkg::UDT_START;
          line.txd <= 1'b0;
        end
        udt_pkg::UDT_START: begin
          if (bit_done) begin
            state    <= udt_pkg::UDT_DATA;
            line.txd <= shreg[0];
            data_idx <= '0;
          end
        end
        udt_pkg::UDT_DATA: begin
          if (bit_done) begin
            if (data_idx == DATA_LAST) begin
              state    <= udt_pkg::UDT_STOP;
              line.txd <= 1'b1;
              stop_idx <= 1'b0;
            end else begin
              shreg    <= shreg >> 1;
              line.txd <= shreg[1];
              data_idx <= data_idx + 1'b1;
            end
          end
        end
        udt_pkg::UDT_STOP: begin
          if (stop_end) begin
            if (load) begin
              state    <= udt_pkg::UDT_START;
              shreg    <= fifo_data;
              line.txd <= 1'b0;
            end else begin
              state                   <= udt_pkg::UDT_IDLE;
              line.line_driver_enable <= 1'b0;
              tx_busy                 <= 1'b0;
            end
          end else if (bit_done) begin
            stop_idx <= 1'b1;
          end
        end
        default: begin
          state <= udt_pkg::UDT_IDLE;
          line  <= udt_pkg::LINE_RESET;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_enable_on_write: assert property (@(posedge clk) disable iff (sys_rst)
    (state == udt_pkg::UDT_IDLE && fifo_valid && !flow_ctrl_en)
      |=> line.line_driver_enable)
    else $error("driver not enabled after character written");

  a_enable_hold_b2b: assert property (@(posedge clk) disable iff (sys_rst)
    (stop_end && can_load)
      |=> line.line_driver_enable && !line.txd && state == udt_pkg::UDT_START)
    else $error("driver enable dropped between characters");

  a_enable_drop_end: assert property (@(posedge clk) disable iff (sys_rst)
    (stop_end && !can_load)
      |=> !line.line_driver_enable && line.txd && $past(line.txd))
    else $error("driver enable not released at stop end");

  a_cts_latency: assert property (@(posedge clk) disable iff (sys_rst)
    ($fell(cts_n) && flow_ctrl_en && fifo_valid && state == udt_pkg::UDT_IDLE)
      |-> ##[2:CTS_LAT_MAX] line.line_driver_enable)
    else $error("driver enable later than cts latency limit");

  a_cts_window: assert property (@(posedge clk) disable iff (sys_rst)
    ($fell(cts_n) && flow_ctrl_en && fifo_valid && state == udt_pkg::UDT_IDLE)
      |-> !line.line_driver_enable [*2] ##[1:6] line.line_driver_enable)
    else $error("driver enable outside cts window");

  a_flow_start: assert property (@(posedge clk) disable iff (sys_rst)
    (state == udt_pkg::UDT_IDLE && load && flow_ctrl_en)
      |=> line.line_driver_enable && !line.txd)
    else $error("start edge not with enable under flow control");

  a_start_gap: assert property (@(posedge clk) disable iff (sys_rst)
    ($rose(line.line_driver_enable) && !$past(flow_ctrl_en))
      |-> line.txd ##1 !line.txd)
    else $error("start edge not one clock after enable");

  a_sync_agree: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(cts_flt) |-> $past(cts_s2) == $past(cts_s3) && cts_flt == $past(cts_s3))
    else $error("cts used before stages agree");

  a_line_idle: assert property (@(posedge clk) disable iff (sys_rst)
    !line.line_driver_enable |-> line.txd)
    else $error("line driven low while driver disabled");

endmodule
